// ---- design/pcl_pkg.sv ----
// package of constants and types shared by both ends of the power-up config loader
package pcl_pkg;
  // =====================================================================
  // clock and timing
  // =====================================================================
  localparam int unsigned CLK_MHZ        = 200;        // core_clk rate in MHz
  localparam int unsigned SETTLE_MS      = 10;         // quiet window after reset, ms
  localparam int unsigned LOAD_MS        = 1;          // undisturbed time after a pin change, ms
  localparam int unsigned CYC_PER_MS     = CLK_MHZ * 1000;
  localparam int unsigned SETTLE_CYC     = SETTLE_MS * CYC_PER_MS;  // least time, exact
  localparam int unsigned LOAD_CYC       = LOAD_MS * CYC_PER_MS;    // least time, exact
  localparam int unsigned CNT_W          = 32;         // width of timing counters
  // =====================================================================
  // configuration store layout
  // =====================================================================
  localparam int unsigned NUM_CFG        = 4;          // stored power-up configurations
  localparam int unsigned IDX_W          = 2;          // width of a configuration index
  localparam int unsigned CFG_W          = 32;         // width of one configuration word
  localparam int unsigned LOAD_WORDS     = 8;          // words copied per configuration load
  localparam int unsigned WADDR_W        = 3;          // word address within a config
  localparam logic [IDX_W-1:0] CFG_ZERO  = 2'h0;       // index of configuration 0
  localparam logic [CFG_W-1:0] SERIAL_DEFAULT = 32'h0000_0000; // serial-bus default word
  // =====================================================================
  // loader states
  // =====================================================================
  typedef enum logic [4:0] {
    PCL_RESET  = 5'b00001,   // waiting for the first edge after release
    PCL_LOAD   = 5'b00010,   // copying a configuration into live registers
    PCL_SETTLE = 5'b00100,   // quiet window after power-up
    PCL_RUN    = 5'b01000,   // watching select pins
    PCL_HOLD   = 5'b10000    // undisturbed period after a switch
  } pcl_state_t;
endpackage : pcl_pkg

// ---- design/pcl_if.sv ----
// interface joining the select-pin controller to the configuration loader
`timescale 1ns/1ps
`default_nettype none
interface pcl_if;
  logic mode_select_pin;        // low selects software mode, high hardware select
  logic config_index_low_pin;   // low bit of the configuration index
  logic config_index_high_pin;  // high bit of the configuration index
  // device end samples the pins
  modport device (input mode_select_pin, input config_index_low_pin,
                  input config_index_high_pin);
  // controller end drives the pins
  modport ctrl (output mode_select_pin, output config_index_low_pin,
                output config_index_high_pin);
endinterface : pcl_if
`default_nettype wire

// ---- design/pcl_loader.sv ----
// configuration loader: mode capture at reset, config store, pin-driven reloads
`timescale 1ns/1ps
`default_nettype none
module pcl_loader
  import pcl_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC,  // shortened in simulation
  parameter int unsigned LOAD_CYCLES   = LOAD_CYC     // shortened in simulation
) (
  input  wire logic               core_clk,        // device clock
  input  wire logic               resetn,          // power-on reset, active low
  pcl_if.device                   pins,            // select pins from the controller
  input  wire logic               otp_load_at_powerup_bit, // otp load flag
  input  wire logic               store_we,        // write strobe into config store
  input  wire logic [IDX_W-1:0]   store_cfg,       // config written
  input  wire logic [WADDR_W-1:0] store_addr,      // word within config
  input  wire logic [CFG_W-1:0]   store_data,      // word value
  input  wire logic               serial_we,       // serial-bus register write
  input  wire logic [WADDR_W-1:0] serial_addr,     // serial-bus register address
  input  wire logic [CFG_W-1:0]   serial_data,     // serial-bus register data
  input  wire logic [WADDR_W-1:0] live_addr,       // live register read address
  output logic [CFG_W-1:0]        live_data,       // live register read data
  output logic                    hw_mode,         // 1 = hardware select mode
  output logic                    serial_enable,   // 1 = serial access granted
  output logic [IDX_W-1:0]        active_cfg,      // index last loaded
  output logic                    load_busy,       // loader copying words
  output logic                    div_sync_rst     // one-cycle divider sync pulse
);
  // =====================================================================
  // storage
  // =====================================================================
  logic [CFG_W-1:0] store_mem [NUM_CFG*LOAD_WORDS];  // otp image, four banks
  logic [CFG_W-1:0] live_q    [LOAD_WORDS];          // live configuration registers

  // flat address of a word in a bank
  function automatic logic [IDX_W+WADDR_W-1:0] word_at(input logic [IDX_W-1:0] c,
                                                      input logic [WADDR_W-1:0] w);
    word_at = {c, w};
  endfunction : word_at

  // =====================================================================
  // pin synchronisers
  // =====================================================================
  logic [2:0] sync1_q;   // first stage, read only by second
  logic [2:0] sync2_q;   // second stage, safe to use
  // no reset here: the stages keep following the pins while the loader is
  // held, so the levels seen at the first edge after release are the strapped ones
  always_ff @(posedge core_clk) begin
    sync1_q <= {pins.mode_select_pin, pins.config_index_high_pin,
                pins.config_index_low_pin};
    sync2_q <= sync1_q;
  end
  logic              mode_s;  // synchronised mode pin
  logic [IDX_W-1:0]  sel_s;   // synchronised index, high pin as upper bit
  assign mode_s = sync2_q[2];
  assign sel_s  = sync2_q[1:0];

  // =====================================================================
  // store write port (factory / in-system programming)
  // =====================================================================
  // the store is plain memory, no reset: it stands for non-volatile cells
  always_ff @(posedge core_clk) begin
    if (store_we) begin
      store_mem[word_at(store_cfg, store_addr)] <= store_data;
    end
  end

  // =====================================================================
  // loader control
  // =====================================================================
  pcl_state_t        state_q, state_d;     // loader state
  logic [CNT_W-1:0]  cnt_q, cnt_d;         // settle / hold counter
  logic [WADDR_W-1:0] widx_q, widx_d;      // word being copied
  logic [IDX_W-1:0]  cfg_q, cfg_d;         // active index
  logic [IDX_W-1:0]  seen_q, seen_d;       // pin index last acted on
  logic              hw_q, hw_d;           // captured mode
  logic              dflt_q, dflt_d;       // loading serial defaults
  logic              ser_q, ser_d;         // serial access granted
  logic              sync_q, sync_d;       // divider sync pulse
  logic              pin_load_q, pin_load_d; // current load came from pins
  logic              busy_q, busy_d;       // copy in progress, registered output

  // next-state computation
  always_comb begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    widx_d     = widx_q;
    cfg_d      = cfg_q;
    seen_d     = seen_q;
    hw_d       = hw_q;
    dflt_d     = dflt_q;
    ser_d      = ser_q;
    sync_d     = 1'b0;
    pin_load_d = pin_load_q;
    case (state_q)
      PCL_RESET: begin
        // pins were held stable through reset by the controller
        hw_d   = mode_s;
        ser_d  = ~mode_s;
        dflt_d = ~mode_s & otp_load_at_powerup_bit;
        cfg_d  = mode_s ? sel_s : CFG_ZERO;
        seen_d = sel_s;
        widx_d = '0;
        pin_load_d = mode_s;
        state_d = PCL_LOAD;
      end
      PCL_LOAD: begin
        // one word per cycle; eight cycles is far inside the hold window
        if (widx_q == WADDR_W'(LOAD_WORDS - 1)) begin
          widx_d  = '0;
          sync_d  = pin_load_q;
          dflt_d  = 1'b0;
          state_d = (cnt_q == '0) ? PCL_SETTLE : PCL_HOLD;
          cnt_d   = (cnt_q == '0) ? CNT_W'(SETTLE_CYCLES) : cnt_q;
        end else begin
          widx_d = widx_q + WADDR_W'(1);
        end
        if (cnt_q != '0) begin
          cnt_d = (widx_q == WADDR_W'(LOAD_WORDS - 1)) ? cnt_q - CNT_W'(1)
                                                        : cnt_q - CNT_W'(1);
        end
      end
      PCL_SETTLE: begin
        // pin moves here are ignored, index re-read at the end
        if (cnt_q <= CNT_W'(1)) begin
          cnt_d   = '0;
          seen_d  = sel_s;
          state_d = PCL_RUN;
        end else begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
      PCL_RUN: begin
        // only hardware mode follows the pins after the window
        if (hw_q && (sel_s != seen_q)) begin
          seen_d     = sel_s;
          cfg_d      = sel_s;
          widx_d     = '0;
          pin_load_d = 1'b1;
          cnt_d      = CNT_W'(LOAD_CYCLES);
          state_d    = PCL_LOAD;
        end
      end
      PCL_HOLD: begin
        // controller leaves pins alone for the load period
        if (cnt_q <= CNT_W'(1)) begin
          cnt_d   = '0;
          state_d = PCL_RUN;
        end else begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
      default: begin
        state_d = PCL_RESET;
      end
    endcase
    // busy follows the next state so the output flop matches the state flop
    busy_d = (state_d == PCL_LOAD);
  end

  // register the control state
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q    <= PCL_RESET;
      cnt_q      <= '0;
      widx_q     <= '0;
      cfg_q      <= CFG_ZERO;
      seen_q     <= CFG_ZERO;
      hw_q       <= 1'b0;
      dflt_q     <= 1'b0;
      ser_q      <= 1'b0;
      sync_q     <= 1'b0;
      pin_load_q <= 1'b0;
      busy_q     <= 1'b0;
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      widx_q     <= widx_d;
      cfg_q      <= cfg_d;
      seen_q     <= seen_d;
      hw_q       <= hw_d;
      dflt_q     <= dflt_d;
      ser_q      <= ser_d;
      sync_q     <= sync_d;
      pin_load_q <= pin_load_d;
      busy_q     <= busy_d;
    end
  end

  // =====================================================================
  // live registers: loader copy or serial write
  // =====================================================================
  // a serial write landing during a load is dropped, the copy has priority;
  // software mode loads only once, so this costs nothing in practice
  always_ff @(posedge core_clk) begin
    if (state_q == PCL_LOAD) begin
      live_q[widx_q] <= dflt_q ? SERIAL_DEFAULT
                               : store_mem[word_at(cfg_q, widx_q)];
    end else if (serial_we && ser_q) begin
      live_q[serial_addr] <= serial_data;
    end
  end

  // registered outputs
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      live_data <= '0;
    end else begin
      live_data <= live_q[live_addr];
    end
  end
  assign hw_mode       = hw_q;
  assign serial_enable = ser_q;
  assign active_cfg    = cfg_q;
  assign load_busy     = busy_q;
  assign div_sync_rst  = sync_q;
endmodule : pcl_loader
`default_nettype wire

// ---- design/pcl_ctrl.sv ----
// system controller end: drives mode and select pins under the timing limits
`timescale 1ns/1ps
`default_nettype none
module pcl_ctrl
  import pcl_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC,  // shortened in simulation
  parameter int unsigned LOAD_CYCLES   = LOAD_CYC     // shortened in simulation
) (
  input  wire logic             core_clk,     // controller clock
  input  wire logic             resetn,       // reset, active low
  pcl_if.ctrl                   pins,         // pins toward the device
  input  wire logic             mode_strap,   // mode level to present at reset
  input  wire logic [IDX_W-1:0] boot_cfg,     // index held through reset
  input  wire logic             req_valid,    // request a new index
  input  wire logic [IDX_W-1:0] req_cfg,      // requested index
  output logic                  req_ready     // high when a request is taken
);
  // =====================================================================
  // pin state: one bit changed per step
  // =====================================================================
  logic             mode_q;            // driven mode level
  logic [IDX_W-1:0] sel_q, sel_d;      // driven index
  logic [CNT_W-1:0] cnt_q, cnt_d;      // wait counter
  logic             armed_q, armed_d;  // settle window over
  logic [IDX_W-1:0] tgt_q, tgt_d;      // target index
  logic             ready_q, ready_d;  // request acceptance flag

  // next values: hold pins until 10ms, then step one pin per 1ms
  always_comb begin
    sel_d   = sel_q;
    cnt_d   = cnt_q;
    armed_d = armed_q;
    tgt_d   = tgt_q;
    ready_d = 1'b0;
    if (!armed_q) begin
      if (cnt_q >= CNT_W'(SETTLE_CYCLES)) begin
        armed_d = 1'b1;
        cnt_d   = '0;
      end else begin
        cnt_d = cnt_q + CNT_W'(1);
      end
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - CNT_W'(1);
    end else if (tgt_q != sel_q) begin
      // flip the low pin first if it differs, else the high pin
      if (tgt_q[0] != sel_q[0]) begin
        sel_d[0] = tgt_q[0];
      end else begin
        sel_d[1] = tgt_q[1];
      end
      cnt_d = CNT_W'(LOAD_CYCLES);
    end else if (req_valid && !ready_q) begin
      tgt_d   = req_cfg;
      ready_d = 1'b1;
    end
  end

  // register; reset values are constants, boot levels caught after release
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sel_q   <= CFG_ZERO;
      mode_q  <= 1'b0;
      cnt_q   <= '0;
      armed_q <= 1'b0;
      tgt_q   <= CFG_ZERO;
      ready_q <= 1'b0;
    end else if (!armed_q && cnt_q == '0) begin
      sel_q   <= boot_cfg;
      mode_q  <= mode_strap;
      tgt_q   <= boot_cfg;
      cnt_q   <= cnt_d;
    end else begin
      sel_q   <= sel_d;
      cnt_q   <= cnt_d;
      armed_q <= armed_d;
      tgt_q   <= tgt_d;
      ready_q <= ready_d;
    end
  end

  assign pins.mode_select_pin       = mode_q;
  assign pins.config_index_low_pin  = sel_q[0];
  assign pins.config_index_high_pin = sel_q[1];
  assign req_ready                  = ready_q;
endmodule : pcl_ctrl
`default_nettype wire

// ---- bench/pcl_assertions.sv ----
// concurrent checks on the select pins and the loader outputs
`timescale 1ns/1ps
`default_nettype none
module pcl_assertions
  import pcl_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = 200,  // quiet window after release
  parameter int unsigned LOAD_CYCLES   = 40    // undisturbed time after a pin change
) (
  input wire logic             core_clk,
  input wire logic             resetn,
  input wire logic             config_index_low_pin,
  input wire logic             config_index_high_pin,
  input wire logic             hw_mode,
  input wire logic             serial_enable,
  input wire logic [IDX_W-1:0] active_cfg,
  input wire logic             load_busy,
  input wire logic             div_sync_rst
);
  // =====================================================================
  // helper counters
  // =====================================================================
  logic [31:0]      up_q, up_d;    // edges since release
  logic [31:0]      age_q, age_d;  // edges since the pins last moved
  logic [31:0]      at_q, at_d;    // up count when the pins last moved
  logic [IDX_W-1:0] pin_q, pin_d;  // index seen at the last edge
  // pin history; runs are short, so no saturation is needed
  always_comb begin
    up_d  = up_q + 32'h1;
    pin_d = {config_index_high_pin, config_index_low_pin};
    age_d = (pin_d != pin_q) ? 32'h0 : age_q + 32'h1;
    at_d  = (pin_d != pin_q) ? up_q : at_q;
  end
  // registers only
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      up_q  <= 32'h0;
      age_q <= 32'h0;
      at_q  <= 32'h0;
      pin_q <= 2'h0;
    end else begin
      up_q  <= up_d;
      age_q <= age_d;
      at_q  <= at_d;
      pin_q <= pin_d;
    end
  end
  // =====================================================================
  // assertions
  // =====================================================================
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  a_mode_stable: assert property (resetn && $past(resetn) && $past(resetn, 2) |-> $stable(hw_mode))
    else $error("mode changed after capture");
  a_serial_gate: assert property ($past(resetn) |-> serial_enable != hw_mode)
    else $error("serial access not opposite to mode");
  a_load_eight: assert property ($rose(load_busy) |-> load_busy [*8] ##1 !load_busy)
    else $error("load did not last eight cycles");
  a_cfg_on_load: assert property ($past(resetn) && $changed(active_cfg) |-> load_busy)
    else $error("index moved without a load");
  a_sw_no_sync: assert property (!hw_mode |-> !div_sync_rst)
    else $error("sync pulse in software mode");
  a_pin_reload: assert property (hw_mode && age_q == LOAD_CYCLES - 1 &&
    at_q > SETTLE_CYCLES + 16 |-> active_cfg == pin_q && !load_busy)
    else $error("pin index not loaded in time");
  a_one_pin: assert property (!($changed(config_index_low_pin) &&
    $changed(config_index_high_pin)))
    else $error("both select pins moved together");
  a_sync_after: assert property (hw_mode && $fell(load_busy) |-> ##[0:1] div_sync_rst)
    else $error("no sync pulse after hardware load");
  a_sync_single: assert property (div_sync_rst |=> !div_sync_rst)
    else $error("sync pulse longer than one cycle");
  a_settle_quiet: assert property ($rose(load_busy) |-> up_q < 32'h4 || up_q >= SETTLE_CYCLES)
    else $error("load inside the quiet window");
endmodule : pcl_assertions
`default_nettype wire

// ---- bench/powerup_config_select_loader_tb.sv ----
// self-checking bench joining the controller and the loader across the select pins
`timescale 1ns/1ps
`default_nettype none
module powerup_config_select_loader_tb;
  import pcl_pkg::*;
  // =====================================================================
  // signals
  // =====================================================================
  localparam int unsigned SETTLE_N = 200;  // shortened quiet window
  localparam int unsigned LOAD_N   = 40;   // shortened hold window
  logic               core_clk    = 1'b0;  // 200 MHz
  logic               resetn      = 1'b0;  // loader reset
  logic               ctrl_resetn = 1'b0;  // controller reset, released first
  logic               mode_strap  = 1'b1;
  logic [IDX_W-1:0]   boot_cfg    = 2'h0;
  logic               otp_bit     = 1'b0;
  logic               req_valid   = 1'b0;
  logic [IDX_W-1:0]   req_cfg     = 2'h0;
  logic               store_we    = 1'b0;
  logic [IDX_W-1:0]   store_cfg   = 2'h0;
  logic [WADDR_W-1:0] store_addr  = 3'h0;
  logic [CFG_W-1:0]   store_data  = 32'h0;
  logic               serial_we   = 1'b0;
  logic [WADDR_W-1:0] serial_addr = 3'h0;
  logic [CFG_W-1:0]   serial_data = 32'h0;
  logic [WADDR_W-1:0] live_addr   = 3'h0;
  logic [CFG_W-1:0]   live_data, rd;
  logic               req_ready, hw_mode, serial_enable, load_busy, div_sync_rst;
  logic [IDX_W-1:0]   active_cfg, cfg_was;
  int                 n_fail = 0, total_checks = 0, n_sync = 0;
  pcl_if pins_if ();
  pcl_ctrl #(.SETTLE_CYCLES(SETTLE_N), .LOAD_CYCLES(LOAD_N)) pcl_ctrl_inst (
    .core_clk(core_clk), .resetn(ctrl_resetn), .pins(pins_if.ctrl), .mode_strap(mode_strap),
    .boot_cfg(boot_cfg), .req_valid(req_valid), .req_cfg(req_cfg), .req_ready(req_ready));
  pcl_loader #(.SETTLE_CYCLES(SETTLE_N), .LOAD_CYCLES(LOAD_N)) pcl_loader_inst (
    .core_clk(core_clk), .resetn(resetn), .pins(pins_if.device),
    .otp_load_at_powerup_bit(otp_bit), .store_we(store_we), .store_cfg(store_cfg),
    .store_addr(store_addr), .store_data(store_data), .serial_we(serial_we),
    .serial_addr(serial_addr), .serial_data(serial_data), .live_addr(live_addr),
    .live_data(live_data), .hw_mode(hw_mode), .serial_enable(serial_enable),
    .active_cfg(active_cfg), .load_busy(load_busy), .div_sync_rst(div_sync_rst));
  pcl_assertions #(.SETTLE_CYCLES(SETTLE_N), .LOAD_CYCLES(LOAD_N)) pcl_assertions_inst (
    .core_clk(core_clk), .resetn(resetn), .config_index_low_pin(pins_if.config_index_low_pin),
    .config_index_high_pin(pins_if.config_index_high_pin), .hw_mode(hw_mode),
    .serial_enable(serial_enable), .active_cfg(active_cfg), .load_busy(load_busy),
    .div_sync_rst(div_sync_rst));
  // =====================================================================
  // clock, pulse counter, watchdog
  // =====================================================================
  always #2.5 core_clk = ~core_clk;
  // counts divider sync pulses since the last loader release in boot
  always @(negedge core_clk) begin
    if (div_sync_rst === 1'b1) n_sync <= n_sync + 1;
  end
  // whole run is some 1500 cycles; twenty times that means a hang
  initial begin
    repeat (30000) @(posedge core_clk);
    n_fail++;
    $display("watchdog expired");
    stop_test();
  end
  // =====================================================================
  // tasks
  // =====================================================================
  // distinct word per configuration and address
  function automatic logic [CFG_W-1:0] word_of(input int c, input int w);
    return {16'hC0F6, 6'h0, IDX_W'(c), 5'h0, WADDR_W'(w)};
  endfunction : word_of
  task automatic check(input string what, input logic [CFG_W-1:0] seen,
                       input logic [CFG_W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // registered read: address at one falling edge, data at the next
  task automatic live_read(input int a);
    live_addr = WADDR_W'(a);
    @(negedge core_clk);
    rd = live_data;
  endtask : live_read
  task automatic serial_write(input int a, input logic [CFG_W-1:0] d);
    serial_addr = WADDR_W'(a);
    serial_data = d;
    serial_we   = 1'b1;
    @(negedge core_clk);
    serial_we = 1'b0;
    @(negedge core_clk);
  endtask : serial_write
  // all eight live words against config c, or the serial default
  task automatic check_words(input int c, input logic dflt);
    for (int w = 0; w < LOAD_WORDS; w++) begin
      live_read(w);
      check("live word", rd, dflt ? SERIAL_DEFAULT : word_of(c, w));
    end
  endtask : check_words
  // strap levels stay put through reset; loader released after the pins settle
  task automatic boot(input logic m, input int c, input logic otp);
    resetn      = 1'b0;
    ctrl_resetn = 1'b0;
    mode_strap  = m;
    boot_cfg    = IDX_W'(c);
    otp_bit     = otp;
    repeat (5) @(negedge core_clk);
    ctrl_resetn = 1'b1;
    repeat (4) @(negedge core_clk);
    resetn = 1'b1;
    n_sync = 0;
    repeat (20) @(negedge core_clk);
  endtask : boot
  // controller steps the pins one at a time; wait out every hold window
  task automatic request(input int c);
    int i;
    req_cfg   = IDX_W'(c);
    req_valid = 1'b1;
    for (i = 0; i < 1000 && req_ready !== 1'b1; i++) @(negedge core_clk);
    if (i == 1000) check("request taken", 32'h0, 32'h1);
    req_valid = 1'b0;
    repeat (3 * (LOAD_N + 1) + 20) @(negedge core_clk);
  endtask : request
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  // =====================================================================
  // scenarios
  // =====================================================================
  initial begin
    // store filled while the loader is held in reset
    for (int k = 0; k < NUM_CFG * LOAD_WORDS; k++) begin
      @(negedge core_clk);
      {store_cfg, store_addr} = 5'(k);
      store_data = word_of(k / LOAD_WORDS, k % LOAD_WORDS);
      store_we   = 1'b1;
    end
    @(negedge core_clk);
    store_we = 1'b0;
    // hardware mode: every pin index loads its configuration
    for (int c = 0; c < NUM_CFG; c++) begin
      boot(1'b1, c, 1'b0);
      check("hw_mode", 32'(hw_mode), 32'h1);
      check("serial_enable", 32'(serial_enable), 32'h0);
      check("active_cfg", 32'(active_cfg), 32'(c));
      check("power-up sync", 32'(n_sync), 32'h1);
      check_words(c, 1'b0);
    end
    // serial write refused in hardware mode
    serial_write(2, 32'hDEAD_BEEF);
    live_read(2);
    check("word after refused write", rd, word_of(3, 2));
    repeat (SETTLE_N + 20) @(negedge core_clk);
    request(1);
    check("index after switch", 32'(active_cfg), 32'h1);
    check_words(1, 1'b0);
    check("switch sync", 32'(n_sync), 32'h2);
    request(2);
    check("index after two steps", 32'(active_cfg), 32'h2);
    check("step sync", 32'(n_sync), 32'h4);
    // software mode, load bit set: serial defaults, pins ignored
    boot(1'b0, 3, 1'b1);
    check("hw_mode", 32'(hw_mode), 32'h0);
    check("serial_enable", 32'(serial_enable), 32'h1);
    check_words(0, 1'b1);
    serial_write(5, 32'hA5A5_5A5A);
    live_read(5);
    check("serial override", rd, 32'hA5A5_5A5A);
    cfg_was = active_cfg;
    repeat (SETTLE_N + 20) @(negedge core_clk);
    request(1);
    check("index kept", 32'(active_cfg), 32'(cfg_was));
    live_read(5);
    check("override kept", rd, 32'hA5A5_5A5A);
    check("no sync in sw mode", 32'(n_sync), 32'h0);
    // software mode, load bit clear: configuration 0 whatever the pins say
    boot(1'b0, 3, 1'b0);
    check_words(0, 1'b0);
    // hardware mode, loader held back: pin moves inside its quiet window are ignored
    boot(1'b1, 2, 1'b0);
    resetn = 1'b0;
    repeat (100) @(negedge core_clk);
    resetn = 1'b1;
    repeat (90) @(negedge core_clk);
    request(1);
    check("index held through window", 32'(active_cfg), 32'h2);
    stop_test();
  end
endmodule : powerup_config_select_loader_tb
`default_nettype wire
